//--- pkg/pisq_pkg.sv
// Purpose: shared constants and types of the pump interlock and start sequencer
// Assumes: 100 MHz pclk, APB register access
// Notes:   offsets are byte addresses of aligned 32-bit words
package pisq_pkg;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_DELAY     = 8'h04;
  localparam logic [7:0]  OFS_LEVELS    = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h14;
  localparam logic [7:0]  OFS_REF       = 8'h18;
  // control and levels word layout
  localparam int          CTRL_SEL_LSB  = 0;
  localparam int          CTRL_AUX_LSB  = 4;
  localparam int          CTRL_BYP_BIT  = 8;
  localparam int          LVL_STOP_LSB  = 16;
  // interlock settings
  localparam logic [2:0]  SEL_OFF       = 3'h0;
  localparam logic [2:0]  SEL_EXTERNAL  = 3'h6;
  localparam int          LOCAL_INPUTS  = 5;
  localparam int          EXP_INPUTS    = 4;
  localparam int          MOTORS        = 4;
  // reset values and interlock alarm code
  localparam logic [15:0] RST_DELAY     = 16'h0000;
  localparam logic [15:0] RST_START_LVL = 16'h8000;
  localparam logic [15:0] RST_STOP_LVL  = 16'h2000;
  localparam logic [7:0]  ALARM_ILK     = 8'h1E;
  // interrupt bits
  localparam int          IRQ_ALARM     = 0;
  localparam int          IRQ_TRIP      = 1;
  localparam int          IRQ_RUN       = 2;
  localparam int          IRQ_BITS      = 3;
  // start delay counts in ticks of one millisecond
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          TICK_TIME_NS  = 1000000;
  localparam int          TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CLOSE = 2'b01,
    ST_RUN   = 2'b11
  } pisq_state_type;
endpackage

//--- hdl/pisq_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to pclk
// Notes:   only the second stage leaves the module
`timescale 1ns/10ps
`default_nettype none
module pisq_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pisq_sync_state_type;
  pisq_sync_state_type r_reg;
  pisq_sync_state_type r_next;
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = din;
    r_next.s2 = r_reg.s1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
  assign dout = r_reg.s2;
endmodule
`default_nettype wire

//--- hdl/pisq_ilk_map.sv
// Purpose: maps interlock inputs onto motors
// Assumes: inputs already synchronised
// Notes:   ok high means the motor may run
`timescale 1ns/10ps
`default_nettype none
module pisq_ilk_map (
  input  wire logic [2:0] sel,
  input  wire logic [1:0] aux_n,
  input  wire logic [4:0] loc,
  input  wire logic [3:0] expn,
  output logic      [3:0] present,
  output logic      [3:0] ok
);
  logic [8:0] pos;
  assign pos = {expn, loc};
  genvar m;
  generate
    for (m = 0; m < pisq_pkg::MOTORS; m++) begin : g_motor
      logic [3:0] idx;
      // consecutive inputs from the selected local one, then the modules
      // external setting starts at module 1 input one
      assign idx = (sel == pisq_pkg::SEL_EXTERNAL) ? 4'(pisq_pkg::LOCAL_INPUTS + m) : 4'({1'b0, sel} - 4'h1 + 4'(m));
      assign present[m] = (2'(m) <= aux_n) || (m == 0);
      // active low, unmapped positions ignored, setting 0 disables
      assign ok[m] = (sel == pisq_pkg::SEL_OFF) || (sel == 3'h7) || !present[m] || pos[idx];
    end
  endgenerate
endmodule
`default_nettype wire

//--- hdl/pisq_top.sv
// Purpose: interlock handling and start sequencing of a pump_fan_control group
// Assumes: pid_output and actual_value come from logic on pclk
// Notes:   motor 0 is the speed-regulated motor, motors 1..3 auxiliaries
// What this block does
// - interlocks run consecutively from chosen local input
// - external setting takes all interlocks from modules
// - interlock inputs are active low
// - interlocked speed motor refuses start, alarm 30
// - switched-off motor skipped, next one started
// - tripped thermal relay stops its motor
// - bypass selects actual value as reference
// - bypass bases auxiliary start/stop on actual value
// - contactor first, delay, then energise motor
// - one start delay serves every motor
// - setting zero disables interlock handling entirely
// - skip interlocked motors; alarm when every idle auxiliary is interlocked
`timescale 1ns/10ps
`default_nettype none
module pisq_top #(
  parameter int TICK_CYCLES = pisq_pkg::TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        start_cmd,
  input  wire logic [4:0]  local_input,
  input  wire logic [3:0]  io_expansion_module_input,
  input  wire logic [15:0] pid_output,
  input  wire logic [15:0] actual_value,
  output logic      [3:0]  contactor,
  output logic             energise,
  output logic      [15:0] freq_ref,
  output logic      [7:0]  alarm_code,
  output logic             irq
);
  typedef struct packed {
    pisq_pkg::pisq_state_type state;
    logic [2:0]  sel;
    logic [1:0]  aux_n;
    logic        bypass;
    logic [15:0] delay;
    logic [15:0] start_lvl;
    logic [15:0] stop_lvl;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic [3:0]  ilk_ok;
    logic [3:0]  present;
    logic [3:0]  contactor;
    logic        energise;
    logic [15:0] dly_cnt;
    logic [16:0] tick;
    logic        aux_pend;
    logic [1:0]  aux_idx;
    logic [7:0]  alarm_code;
    logic [15:0] freq_ref;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
  } pisq_top_state_type;

  pisq_top_state_type r_reg;
  pisq_top_state_type r_next;
  logic               start_s;
  logic [4:0]         loc_s;
  logic [3:0]         exp_s;
  logic [3:0]         map_ok;
  logic [3:0]         map_present;

  // pins pass two flip-flops before use
  pisq_sync #(.W(10)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({start_cmd, io_expansion_module_input, local_input}),
    .dout    ({start_s, exp_s, loc_s})
  );

  pisq_ilk_map u_map (
    .sel     (r_reg.sel),
    .aux_n   (r_reg.aux_n),
    .loc     (loc_s),
    .expn    (exp_s),
    .present (map_present),
    .ok      (map_ok)
  );

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == pisq_pkg::OFS_CTRL) || (a == pisq_pkg::OFS_DELAY) || (a == pisq_pkg::OFS_LEVELS) ||
              (a == pisq_pkg::OFS_STATUS) || (a == pisq_pkg::OFS_IRQ_STAT) || (a == pisq_pkg::OFS_IRQ_MASK) ||
              (a == pisq_pkg::OFS_REF);
  endfunction

  // lowest auxiliary motor present, idle and not interlocked; bit 2 marks found
  function automatic logic [2:0] first_free(input logic [3:0] ok, input logic [3:0] on, input logic [3:0] pr);
    first_free = 3'h0;
    for (int i = pisq_pkg::MOTORS - 1; i >= 1; i--) begin
      if (pr[i] && ok[i] && !on[i]) begin
        first_free = {1'b1, 2'(i)};
      end
    end
  endfunction

  // highest running auxiliary motor; bit 2 marks found
  function automatic logic [2:0] last_on(input logic [3:0] on);
    last_on = 3'h0;
    for (int i = 1; i < pisq_pkg::MOTORS; i++) begin
      if (on[i]) begin
        last_on = {1'b1, 2'(i)};
      end
    end
  endfunction

  logic [15:0] ctrl_sig;
  logic        wr;
  logic        tick_hit;
  logic [2:0]  ev;
  logic [2:0]  clr;
  logic [2:0]  pick;
  logic [2:0]  drop;
  logic [3:0]  idle_aux;

  always_comb begin
    r_next   = r_reg;
    ev       = 3'h0;
    clr      = 3'h0;
    // regulator or actual value drives reference and staging
    ctrl_sig = r_reg.bypass ? actual_value : pid_output;
    wr       = psel && penable && pwrite && r_reg.pready;
    tick_hit = (r_reg.tick == 17'(TICK_CYCLES - 1));
    pick     = first_free(r_reg.ilk_ok, r_reg.contactor, r_reg.present);
    drop     = last_on(r_reg.contactor);
    idle_aux = r_reg.present & ~r_reg.contactor & 4'hE;
    r_next.ilk_ok  = map_ok;
    r_next.present = map_present;
    r_next.tick    = tick_hit ? 17'h00000 : r_reg.tick + 17'h00001;
    r_next.alarm_code = 8'h00;

    // apb slave, one wait-free access, data prepared in setup
    r_next.pready  = psel && !penable;
    r_next.pslverr = psel && !penable && !reg_hit(paddr);
    if (psel && !penable) begin
      case (paddr)
        pisq_pkg::OFS_CTRL: begin
          r_next.prdata = {23'h000000, r_reg.bypass, 2'h0, r_reg.aux_n, 1'b0, r_reg.sel};
        end
        pisq_pkg::OFS_DELAY: begin
          r_next.prdata = {16'h0000, r_reg.delay};
        end
        pisq_pkg::OFS_LEVELS: begin
          r_next.prdata = {r_reg.stop_lvl, r_reg.start_lvl};
        end
        pisq_pkg::OFS_STATUS: begin
          r_next.prdata = {18'h00000, (r_reg.alarm_code != 8'h00), r_reg.energise, r_reg.contactor,
                           r_reg.ilk_ok, r_reg.aux_pend, 1'b0, r_reg.state};
        end
        pisq_pkg::OFS_IRQ_STAT: begin
          r_next.prdata = {29'h00000000, r_reg.irq_stat};
        end
        pisq_pkg::OFS_IRQ_MASK: begin
          r_next.prdata = {29'h00000000, r_reg.irq_mask};
        end
        pisq_pkg::OFS_REF: begin
          r_next.prdata = {16'h0000, r_reg.freq_ref};
        end
        default: begin
          r_next.prdata = 32'h00000000;
        end
      endcase
    end
    if (wr) begin
      case (paddr)
        pisq_pkg::OFS_CTRL: begin
          r_next.sel    = pwdata[pisq_pkg::CTRL_SEL_LSB +: 3];
          r_next.aux_n  = pwdata[pisq_pkg::CTRL_AUX_LSB +: 2];
          r_next.bypass = pwdata[pisq_pkg::CTRL_BYP_BIT];
        end
        pisq_pkg::OFS_DELAY: begin
          r_next.delay = pwdata[15:0];
        end
        pisq_pkg::OFS_LEVELS: begin
          r_next.start_lvl = pwdata[15:0];
          r_next.stop_lvl  = pwdata[pisq_pkg::LVL_STOP_LSB +: 16];
        end
        pisq_pkg::OFS_IRQ_STAT: begin
          clr = pwdata[2:0];
        end
        pisq_pkg::OFS_IRQ_MASK: begin
          r_next.irq_mask = pwdata[2:0];
        end
        default: begin
        end
      endcase
    end

    // one shared delay counter for speed motor and auxiliaries
    if (tick_hit && (r_reg.dly_cnt != 16'h0000)) begin
      r_next.dly_cnt = r_reg.dly_cnt - 16'h0001;
    end

    case (r_reg.state)
      pisq_pkg::ST_IDLE: begin
        r_next.contactor = 4'h0;
        r_next.energise  = 1'b0;
        r_next.aux_pend  = 1'b0;
        if (start_s) begin
          if (!r_reg.ilk_ok[0]) begin
            // refuse start while speed motor interlocked
            r_next.alarm_code = pisq_pkg::ALARM_ILK;
            ev[pisq_pkg::IRQ_ALARM] = 1'b1;
          end else begin
            // close contactor, then wait the delay
            r_next.state     = pisq_pkg::ST_CLOSE;
            r_next.contactor = 4'h1;
            r_next.dly_cnt   = r_reg.delay;
            r_next.tick      = 17'h00000;
          end
        end
      end
      pisq_pkg::ST_CLOSE: begin
        if (!start_s || !r_reg.ilk_ok[0]) begin
          r_next.state = pisq_pkg::ST_IDLE;
          r_next.contactor = 4'h0;
          ev[pisq_pkg::IRQ_TRIP] = !r_reg.ilk_ok[0];
        end else if (r_reg.dly_cnt == 16'h0000) begin
          // energise only after the delay has run out
          r_next.state    = pisq_pkg::ST_RUN;
          r_next.energise = 1'b1;
          ev[pisq_pkg::IRQ_RUN] = 1'b1;
        end
      end
      pisq_pkg::ST_RUN: begin
        if (!start_s || !r_reg.ilk_ok[0]) begin
          // tripped speed motor stops the whole group
          r_next.state     = pisq_pkg::ST_IDLE;
          r_next.contactor = 4'h0;
          r_next.energise  = 1'b0;
          r_next.aux_pend  = 1'b0;
          ev[pisq_pkg::IRQ_TRIP] = !r_reg.ilk_ok[0];
        end else begin
          // tripped auxiliaries drop out at once
          if ((r_reg.contactor & ~r_reg.ilk_ok & 4'hE) != 4'h0) begin
            ev[pisq_pkg::IRQ_TRIP] = 1'b1;
          end
          r_next.contactor = r_reg.contactor & (r_reg.ilk_ok | 4'h1);
          if (r_reg.aux_pend) begin
            if (!r_reg.ilk_ok[r_reg.aux_idx]) begin
              r_next.aux_pend = 1'b0;
            end else if (r_reg.dly_cnt == 16'h0000) begin
              r_next.aux_pend = 1'b0;
              r_next.contactor[r_reg.aux_idx] = 1'b1;
            end
          end else if (ctrl_sig >= r_reg.start_lvl) begin
            if (pick[2]) begin
              // skip switched-off motors, take next free one
              r_next.aux_pend = 1'b1;
              r_next.aux_idx  = pick[1:0];
              r_next.dly_cnt  = r_reg.delay;
              r_next.tick     = 17'h00000;
            end else if (idle_aux != 4'h0) begin
              // every remaining motor interlocked
              r_next.alarm_code = pisq_pkg::ALARM_ILK;
              ev[pisq_pkg::IRQ_ALARM] = 1'b1;
            end
          end else if ((ctrl_sig <= r_reg.stop_lvl) && drop[2]) begin
            r_next.contactor[drop[1:0]] = 1'b0;
          end
        end
      end
      default: begin
        r_next.state     = pisq_pkg::ST_IDLE;
        r_next.contactor = 4'h0;
        r_next.energise  = 1'b0;
      end
    endcase

    r_next.freq_ref = r_next.energise ? ctrl_sig : 16'h0000;
    // set wins over a write-one clear
    r_next.irq_stat = (r_reg.irq_stat & ~clr) | ev;
    r_next.irq      = |(r_next.irq_stat & r_next.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg           <= '0;
      r_reg.state     <= pisq_pkg::ST_IDLE;
      r_reg.delay     <= pisq_pkg::RST_DELAY;
      r_reg.start_lvl <= pisq_pkg::RST_START_LVL;
      r_reg.stop_lvl  <= pisq_pkg::RST_STOP_LVL;
      r_reg.ilk_ok    <= 4'hF;
      r_reg.present   <= 4'h1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata     = r_reg.prdata;
  assign pready     = r_reg.pready;
  assign pslverr    = r_reg.pslverr;
  assign contactor  = r_reg.contactor;
  assign energise   = r_reg.energise;
  assign freq_ref   = r_reg.freq_ref;
  assign alarm_code = r_reg.alarm_code;
  assign irq        = r_reg.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_map_consecutive: assert property ((r_reg.sel == 3'h5) && (r_reg.aux_n == 2'h3) |->
    (map_ok[3] == exp_s[2]) && (map_ok[1] == exp_s[0])) else $error("interlock mapping wrong");
  a_map_external: assert property ((r_reg.sel == 3'h6) |-> (map_ok[0] == exp_s[0]))
    else $error("external interlock mapping wrong");
  a_active_low: assert property ((r_reg.sel == 3'h1) && !loc_s[0] |-> !map_ok[0])
    else $error("low interlock not seen");
  a_refuse_start: assert property ((r_reg.state == pisq_pkg::ST_IDLE) && start_s && !r_reg.ilk_ok[0]
    |=> (r_reg.state == pisq_pkg::ST_IDLE) && (alarm_code == 8'h1E) && !contactor[0]) else $error("start not refused");
  a_skip_switched: assert property ($rose(contactor[1]) |-> $past(r_reg.ilk_ok[1]))
    else $error("interlocked motor started");
  a_thermal_stop: assert property ((r_reg.state == pisq_pkg::ST_RUN) && !r_reg.ilk_ok[0]
    |=> !energise && (contactor == 4'h0)) else $error("tripped motor kept running");
  a_aux_trip: assert property ((r_reg.state == pisq_pkg::ST_RUN) && contactor[1] && !r_reg.ilk_ok[1]
    |=> !contactor[1]) else $error("tripped auxiliary kept running");
  a_bypass_ref: assert property (energise && r_next.energise && r_reg.bypass
    |=> freq_ref == $past(actual_value)) else $error("bypass reference wrong");
  a_bypass_stage: assert property ((r_reg.state == pisq_pkg::ST_RUN) && r_next.energise && r_reg.bypass &&
    !r_reg.aux_pend && (actual_value >= r_reg.start_lvl) && pick[2] |=> r_reg.aux_pend)
    else $error("bypass staging wrong");
  a_contact_first: assert property ($rose(energise) |-> contactor[0] && $past(contactor[0]))
    else $error("energised before contactor");
  a_one_delay: assert property ((r_reg.state == pisq_pkg::ST_IDLE) && (r_next.state == pisq_pkg::ST_CLOSE)
    |=> r_reg.dly_cnt == $past(r_reg.delay)) else $error("delay not loaded");
  a_ilk_off: assert property ((r_reg.sel == 3'h0) |-> (map_ok == 4'hF))
    else $error("interlocks not disabled");
  a_irq_level: assert property (irq == |(r_reg.irq_stat & r_reg.irq_mask))
    else $error("irq mismatch");
endmodule
`default_nettype wire

//--- verif/pisq_partner.sv
// Purpose: far-side model of motor on/off switches and thermal relay contacts
// Assumes: each interlock line has a pull-up; an open contact pulls it low
// Notes:   lines 0..4 are local inputs, 5..8 the expansion module inputs
`timescale 1ns/10ps
`default_nettype none
module pisq_partner (
  input  wire logic [8:0] contact_open,
  output logic      [4:0] local_input,
  output logic      [3:0] io_expansion_module_input
);
  // closed contact keeps the line high, open contact makes it low
  assign local_input               = ~contact_open[4:0];
  assign io_expansion_module_input = ~contact_open[8:5];
endmodule
`default_nettype wire

//--- verif/test_pisq_top.sv
// Purpose: self-checking bench of the interlock and start sequencer
// Assumes: tick of 4 cycles to keep start delays short
// Notes:   all inputs change by non-blocking assignment at the rising edge
`timescale 1ns/10ps
`default_nettype none
module test_pisq_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        start_cmd = 1'b0;
  logic [8:0]  contact_open = 9'h000;
  logic [4:0]  local_input;
  logic [3:0]  io_expansion_module_input;
  logic [15:0] pid_output = 16'h0000;
  logic [15:0] actual_value = 16'h0000;
  logic [3:0]  contactor;
  logic        energise;
  logic [15:0] freq_ref;
  logic [7:0]  alarm_code;
  logic        irq;
  int          errors = 0;
  int          num_checks = 0;
  logic [31:0] q;
  logic        e;
  logic [3:0]  okb;
  logic [3:0]  pm;
  int          n;

  always #5 pclk = ~pclk;

  pisq_top #(.TICK_CYCLES(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_cmd(start_cmd), .local_input(local_input),
    .io_expansion_module_input(io_expansion_module_input), .pid_output(pid_output),
    .actual_value(actual_value), .contactor(contactor), .energise(energise),
    .freq_ref(freq_ref), .alarm_code(alarm_code), .irq(irq)
  );

  pisq_partner u_far (
    .contact_open(contact_open), .local_input(local_input),
    .io_expansion_module_input(io_expansion_module_input)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic timeout();
    errors++;
    $display("BAD %0t wait ran out", $time);
    conclude();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) timeout();
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask

  task automatic set_ctrl(input int s, input int a, input logic byp);
    wr(pisq_pkg::OFS_CTRL, 32'(s) | (32'(a) << 4) | (32'(byp) << 8));
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return contactor[0];
      1: return energise;
      2: return contactor[1];
      3: return contactor[2];
      default: return alarm_code === pisq_pkg::ALARM_ILK;
    endcase
  endfunction

  task automatic wait_for(input int w, input logic v);
    int k = 0;
    while (sig(w) !== v && k < 200) begin
      @(posedge pclk);
      k++;
    end
    if (sig(w) !== v) timeout();
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and refused access
    apb(1'b0, pisq_pkg::OFS_LEVELS, 32'h0, q, e);
    check(q, {pisq_pkg::RST_STOP_LVL, pisq_pkg::RST_START_LVL}, "levels reset");
    apb(1'b0, pisq_pkg::OFS_DELAY, 32'h0, q, e);
    check(q, 32'(pisq_pkg::RST_DELAY), "delay reset");
    apb(1'b0, 8'h1C, 32'h0, q, e);
    check({31'h0, e}, 32'h1, "unmapped error");
    $display("test registers done");
    // every setting, aux count and single open line
    for (int s = 0; s < 8; s++) begin
      for (int a = 0; a < 4; a++) begin
        set_ctrl(s, a, 1'b0);
        for (int l = 0; l < 10; l++) begin
          contact_open <= (l < 9) ? 9'(1 << l) : 9'h000;
          repeat (5) @(posedge pclk);
          apb(1'b0, pisq_pkg::OFS_STATUS, 32'h0, q, e);
          for (int m = 0; m < 4; m++) begin
            okb[m] = (s == 0 || s == 7) ? 1'b1 : (l != ((s == 6) ? 5 : s - 1) + m);
            pm[m]  = (m <= a);
          end
          check(32'(q[7:4] & pm), 32'(okb & pm), "interlock map");
        end
      end
    end
    $display("test mapping done");
    // interlocked speed motor refuses start, alarm and interrupt
    set_ctrl(1, 0, 1'b0);
    contact_open <= 9'h001;
    wr(pisq_pkg::OFS_IRQ_MASK, 32'h1);
    start_cmd <= 1'b1;
    wait_for(4, 1'b1);
    check(32'(contactor), 32'h0, "no start when interlocked");
    start_cmd <= 1'b0;
    repeat (8) @(posedge pclk);
    check({31'h0, irq}, 32'h1, "alarm irq");
    wr(pisq_pkg::OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0, "masked irq");
    wr(pisq_pkg::OFS_IRQ_MASK, 32'h1);
    wr(pisq_pkg::OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    $display("test refusal done");
    // contactor first, shared delay, then energise
    contact_open <= 9'h000;
    wr(pisq_pkg::OFS_DELAY, 32'h2);
    set_ctrl(1, 2, 1'b0);
    pid_output   <= 16'h1234;
    actual_value <= 16'h9000;
    start_cmd    <= 1'b1;
    wait_for(0, 1'b1);
    n = 0;
    while (energise !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, (n >= 8 && n <= 16)}, 32'h1, "start delay");
    repeat (3) @(posedge pclk);
    check(32'(freq_ref), 32'h1234, "regulator reference");
    repeat (40) @(posedge pclk);
    check(32'(contactor[1]), 32'h0, "no aux on low regulator");
    contact_open <= 9'h002;
    set_ctrl(1, 2, 1'b1);
    repeat (3) @(posedge pclk);
    check(32'(freq_ref), 32'h9000, "bypass reference");
    wait_for(3, 1'b1);
    check(32'(contactor[1]), 32'h0, "switched-off motor skipped");
    wait_for(4, 1'b1);
    check(32'(contactor), 32'h5, "alarm with none free");
    $display("test aux start done");
    contact_open <= 9'h006;
    wait_for(3, 1'b0);
    apb(1'b0, pisq_pkg::OFS_IRQ_STAT, 32'h0, q, e);
    check(32'(q[pisq_pkg::IRQ_TRIP]), 32'h1, "trip flag");
    contact_open <= 9'h000;
    wait_for(2, 1'b1);
    actual_value <= 16'h1000;
    wait_for(2, 1'b0);
    check(32'(energise), 32'h1, "speed motor keeps running");
    contact_open <= 9'h001;
    wait_for(0, 1'b0);
    check(32'(energise), 32'h0, "speed motor stopped");
    start_cmd <= 1'b0;
    $display("test run and trip done");
    conclude();
  end
endmodule
`default_nettype wire
